// [design/fbi_cfg.svh]
// Constants for the fault blink indicator
`ifndef FBI_CFG_SVH
`define FBI_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define FBI_CLK_HZ       10000000
`define FBI_PAUSE_MS     1000
`define FBI_ON_MS        200
`define FBI_OFF_MS       300
`define FBI_PAUSE_CYC    ((`FBI_CLK_HZ / 1000) * `FBI_PAUSE_MS)
`define FBI_ON_CYC       ((`FBI_CLK_HZ / 1000) * `FBI_ON_MS)
`define FBI_OFF_CYC      ((`FBI_CLK_HZ / 1000) * `FBI_OFF_MS)

// ****************************************
// Fault field layout
// ****************************************
`define FBI_NUM_FAULTS   6
`define FBI_CODE_W       3
`define FBI_CNT_W        24

`endif

// [design/fbi_code_if.sv]
// Code selection carrier between latch and sequencer
`timescale 1ns/1ps
interface fbi_code_if;
	logic [2:0] code;
	logic       steady;
	modport src (output code, output steady);
	modport dst (input code, input steady);
endinterface

// [design/fbi_latch.sv]
// Fault latch and priority encoder
`timescale 1ns/1ps
`include "fbi_cfg.svh"
module fbi_latch
	import fbi_pkg::*;
#(
	parameter int NUM_FAULTS = `FBI_NUM_FAULTS
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic [NUM_FAULTS-1:0] fault_i,
	input  wire logic                  run_fail_i,
	input  wire logic                  learn_i,
	fbi_code_if.src                    code_o
);
	logic [NUM_FAULTS-1:0] latch_ff;
	logic [NUM_FAULTS-1:0] nxt_latch;
	logic                  fail_ff;
	logic                  nxt_fail;
	logic [2:0]            code_ff;
	logic [2:0]            nxt_code;

	// Latch faults; a fault present during learn survives, set beats clear
	always_comb begin
		nxt_latch = learn_i ? fault_i : (latch_ff | fault_i);
		nxt_fail  = learn_i ? run_fail_i : (fail_ff | run_fail_i);
		nxt_code  = 3'h0;
		// Scan downward so the lowest-numbered code ends up selected
		for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
			if (nxt_latch[i]) begin
				nxt_code = 3'(i + 1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			latch_ff <= '0;
			fail_ff  <= 1'b0;
			code_ff  <= 3'h0;
		end else begin
			latch_ff <= nxt_latch;
			fail_ff  <= nxt_fail;
			code_ff  <= nxt_code;
		end
	end

	assign code_o.code   = code_ff;
	assign code_o.steady = fail_ff;
endmodule

// [design/fbi_pkg.sv]
// Types for the fault blink indicator
package fbi_pkg;
	typedef enum logic [1:0] {
		FBI_IDLE   = 2'b00,
		FBI_ON     = 2'b01,
		FBI_OFF    = 2'b10,
		FBI_PAUSE  = 2'b11
	} fbi_state_t;
endpackage

// [design/fbi_top.sv]
// Fault blink indicator top: latch plus flash sequencer
`timescale 1ns/1ps
`include "fbi_cfg.svh"
module fbi_top
	import fbi_pkg::*;
#(
	parameter int PAUSE_CYC = `FBI_PAUSE_CYC,
	parameter int ON_CYC    = `FBI_ON_CYC,
	parameter int OFF_CYC   = `FBI_OFF_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [5:0] fault_i,
	input  wire logic       run_fail_i,
	input  wire logic       learn_i,
	output logic            led_red_o
);
	// ****************************************
	// Fault latch
	// ****************************************
	fbi_code_if sel_if ();

	fbi_latch #(
		.NUM_FAULTS (`FBI_NUM_FAULTS)
	) u_latch (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.fault_i    (fault_i),
		.run_fail_i (run_fail_i),
		.learn_i    (learn_i),
		.code_o     (sel_if)
	);

	// ****************************************
	// Flash sequencer
	// ****************************************
	fbi_state_t              state_ff;
	fbi_state_t              nxt_state;
	logic [`FBI_CNT_W-1:0]   tmr_ff;
	logic [`FBI_CNT_W-1:0]   nxt_tmr;
	logic [2:0]              flash_ff;
	logic [2:0]              nxt_flash;
	logic [2:0]              code_ff;
	logic [2:0]              nxt_code;
	logic                    led_ff;
	logic                    nxt_led;

	// Code is frozen per group so a change to another nonzero code never truncates a group mid-way
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr   = tmr_ff;
		nxt_flash = flash_ff;
		nxt_code  = code_ff;
		nxt_led   = 1'b0;
		if (sel_if.steady) begin
			nxt_state = FBI_IDLE;
			nxt_led   = 1'b1;
		end else if (sel_if.code == 3'h0) begin
			nxt_state = FBI_IDLE;
		end else begin
			unique case (state_ff)
				FBI_IDLE: begin
					nxt_state = FBI_ON;
					nxt_code  = sel_if.code;
					nxt_flash = 3'h1;
					nxt_tmr   = `FBI_CNT_W'(ON_CYC - 1);
					nxt_led   = 1'b1;
				end
				FBI_ON: begin
					nxt_led = 1'b1;
					if (tmr_ff == '0) begin
						nxt_led = 1'b0;
						if (flash_ff == code_ff) begin
							nxt_state = FBI_PAUSE;
							nxt_tmr   = `FBI_CNT_W'(PAUSE_CYC - 1);
						end else begin
							nxt_state = FBI_OFF;
							nxt_tmr   = `FBI_CNT_W'(OFF_CYC - 1);
						end
					end else begin
						nxt_tmr = tmr_ff - 1'b1;
					end
				end
				FBI_OFF: begin
					if (tmr_ff == '0) begin
						nxt_state = FBI_ON;
						nxt_flash = flash_ff + 3'h1;
						nxt_tmr   = `FBI_CNT_W'(ON_CYC - 1);
						nxt_led   = 1'b1;
					end else begin
						nxt_tmr = tmr_ff - 1'b1;
					end
				end
				FBI_PAUSE: begin
					if (tmr_ff == '0) begin
						nxt_state = FBI_ON;
						nxt_code  = sel_if.code;
						nxt_flash = 3'h1;
						nxt_tmr   = `FBI_CNT_W'(ON_CYC - 1);
						nxt_led   = 1'b1;
					end else begin
						nxt_tmr = tmr_ff - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_ff <= FBI_IDLE;
			tmr_ff   <= '0;
			flash_ff <= 3'h0;
			code_ff  <= 3'h0;
			led_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= nxt_tmr;
			flash_ff <= nxt_flash;
			code_ff  <= nxt_code;
			led_ff   <= nxt_led;
		end
	end

	assign led_red_o = led_ff;
endmodule

// [tb/fbi_partner.sv]
// Fault detector and learn command source model
`timescale 1ns/1ps
module fbi_partner (
	input  wire logic       clk_i,
	output logic      [5:0] fault_o,
	output logic            run_fail_o,
	output logic            learn_o
);
	// Detectors quiet at start
	initial begin
		fault_o = 6'h00;
		run_fail_o = 1'b0;
		learn_o = 1'b0;
	end
	// Change just after an edge, then hold until the next call
	task automatic put(input logic [5:0] f, input logic r, input logic l);
		@(posedge clk_i);
		fault_o <= f;
		run_fail_o <= r;
		learn_o <= l;
	endtask
endmodule

// [tb/fbi_properties.sv]
// Port timing checks for the fault blink indicator
`timescale 1ns/1ps
module fbi_properties #(
	parameter int PAUSE_CYC = 10,
	parameter int ON_CYC    = 3,
	parameter int OFF_CYC   = 4
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [5:0] fault_i,
	input  wire logic       run_fail_i,
	input  wire logic       learn_i,
	input  wire logic       led_red_o
);
	logic [5:0] flt_ff;
	logic       rf_ff;
	// Shadow latches; a set input beats the learn clear
	always_ff @(posedge clk_i) begin
		flt_ff <= rst_b_i ? (fault_i | (flt_ff & {6{!learn_i}})) : 6'h00;
		rf_ff <= rst_b_i ? (run_fail_i | (rf_ff & !learn_i)) : 1'b0;
	end
	// Learn with quiet detectors aborts any group in flight
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i || learn_i);
	AST_ON: assert property ($rose(led_red_o) && !rf_ff |-> ##ON_CYC !led_red_o) else $error("on");
	AST_OFF: assert property ($fell(led_red_o) && !rf_ff |-> !led_red_o[*4]) else $error("off");
	AST_GAP: assert property ($fell(led_red_o) && |flt_ff && !rf_ff |->
		(##OFF_CYC led_red_o) or (##PAUSE_CYC led_red_o)) else $error("gap");
	AST_STEADY: assert property (rf_ff |=> led_red_o) else $error("steady");
	AST_CLEAR: assert property (!(|flt_ff) && !rf_ff |=> !led_red_o) else $error("clear");
	AST_ONE: assert property ($fell(led_red_o) && flt_ff == 6'h01 && !rf_ff
		|-> ##PAUSE_CYC led_red_o) else $error("one");
	AST_TWO: assert property ($rose(led_red_o) && !$past(led_red_o, 5) && flt_ff == 6'h02
		|-> ##7 led_red_o ##7 !led_red_o) else $error("two");
	AST_SIX: assert property ($rose(led_red_o) && !$past(led_red_o, 5) && flt_ff == 6'h20
		|-> ##35 led_red_o ##7 !led_red_o) else $error("six");
endmodule
bind fbi_top fbi_properties #(.PAUSE_CYC(PAUSE_CYC), .ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC)) u_prop (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .fault_i(fault_i), .run_fail_i(run_fail_i),
	.learn_i(learn_i), .led_red_o(led_red_o));

// [tb/tb.sv]
// Self-checking bench for the fault blink indicator
`timescale 1ns/1ps
module tb;
	localparam int ON    = 3;
	localparam int OFF   = 4;
	localparam int PAUSE = 10;
	logic       clk_i;
	logic       rst_b_i;
	logic [5:0] fault_i;
	logic       run_fail_i;
	logic       learn_i;
	logic       led_red_o;
	int         n_mismatch;
	int         checked;
	fbi_partner p (.clk_i(clk_i), .fault_o(fault_i), .run_fail_o(run_fail_i), .learn_o(learn_i));
	fbi_top #(.PAUSE_CYC(PAUSE), .ON_CYC(ON), .OFF_CYC(OFF)) dut (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .fault_i(fault_i), .run_fail_i(run_fail_i),
		.learn_i(learn_i), .led_red_o(led_red_o));
	// Clock, and a watchdog well past the expected run length
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		#300000;
		n_mismatch++;
		report_and_stop();
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// LED must sit at one level for two pause lengths
	task automatic hold(input logic v);
		int n;
		n = 0;
		repeat (2 * PAUSE) begin
			@(negedge clk_i);
			if (led_red_o !== v) n++;
		end
		checked++;
		if (n != 0) begin n_mismatch++; $display("BAD %0t led not %b", $time, v); end
	endtask
	// Learn pulse with quiet detectors; LED goes dark
	task automatic clear();
		p.put(6'h00, 1'b0, 1'b1);
		p.put(6'h00, 1'b0, 1'b0);
		@(negedge clk_i);
		hold(1'b0);
	endtask
	// Two whole group periods hold exactly two groups of k rises
	task automatic flash(input logic [5:0] f, input int k);
		int n;
		logic prv;
		n = 0;
		prv = 1'b0;
		p.put(f, 1'b0, 1'b0);
		repeat (2 * (k * (ON + OFF) - OFF + PAUSE)) begin
			@(negedge clk_i);
			if (led_red_o === 1'b1 && prv === 1'b0) n++;
			prv = led_red_o;
		end
		checked++;
		if (n != 2 * k) begin n_mismatch++; $display("BAD %0t rises %0d", $time, n); end
		clear();
		$display("flash %0d done", k);
	endtask
	// Failed run pulse lights the LED steadily until learn
	task automatic steady();
		p.put(6'h00, 1'b1, 1'b0);
		p.put(6'h00, 1'b0, 1'b0);
		@(negedge clk_i);
		hold(1'b1);
		clear();
		$display("steady done");
	endtask
	// Main sequence
	initial begin
		rst_b_i = 1'b0;
		n_mismatch = 0;
		checked = 0;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		hold(1'b0);
		for (int k = 1; k <= 6; k++) flash(6'(1 << (k - 1)), k);
		flash(6'h28, 4);
		steady();
		report_and_stop();
	end
endmodule
